// ### shared/lichg_cfg.svh
// Constants of the charge-mode controller: times, offsets, field positions.
// Assumes a single 250 MHz clock; included by bare name.
`ifndef LICHG_CFG_SVH
`define LICHG_CFG_SVH
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define LICHG_CLK_NS        4
`define LICHG_TICK_NS       1000000
`define LICHG_TICK_CYC      (`LICHG_TICK_NS / `LICHG_CLK_NS)
`define LICHG_SECOND_MS     1000
`define LICHG_HOUR_MIN      60
`define LICHG_HOUR_MS       (`LICHG_HOUR_MIN * 60 * 1000)
`define LICHG_BLINK_MHZ     800
`define LICHG_BLINK_HALF_MS (1000000 / (2 * `LICHG_BLINK_MHZ))
// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define LICHG_OFS_CTRL      8'h00
`define LICHG_OFS_STATUS    8'h04
`define LICHG_OFS_ISTAT     8'h08
`define LICHG_OFS_IMASK     8'h0c
`define LICHG_CTRL_RST      32'h00000001
`define LICHG_CTRL_EN_BIT   0
`define LICHG_EV_FAULT      0
`define LICHG_EV_DEFECT     1
`define LICHG_EV_DONE       2
`define LICHG_EV_UVR        3
`define LICHG_EV_W          4
`endif

// ### shared/lichg_pkg.sv
// Types of the charge-mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
package lichg_pkg;
    // One-hot charge modes.
    typedef enum logic [10:0] {
        LC_RESET   = 11'h001,
        LC_STANDBY = 11'h002,
        LC_START   = 11'h004,
        LC_COND    = 11'h008,
        LC_FAST    = 11'h010,
        LC_EOCWAIT = 11'h020,
        LC_TOPOFF  = 11'h040,
        LC_MONITOR = 11'h080,
        LC_BOOST   = 11'h100,
        LC_DEFECT  = 11'h200,
        LC_FAULT   = 11'h400
    } lichg_state_e;
    // Current regulation reference choice.
    typedef enum logic [1:0] {
        LC_IREF_FAST  = 2'h0,
        LC_IREF_COND  = 2'h1,
        LC_IREF_BOOST = 2'h2
    } lichg_iref_e;
endpackage

// ### shared/lichg_time_if.sv
// Time base signals shared between the prescaler and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface lichg_time_if;
    logic tick;
    logic blink;
    modport src (output tick, output blink);
    modport dst (input tick, input blink);
endinterface

// ### core/lichg_sync.sv
// Two-flop synchroniser bank for pins and comparator flags.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ns
module lichg_sync #(
    parameter int W = 12
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;
    if (W < 1) begin : g_chk
        $error("lichg_sync width must be positive");
    end
    // Each bit passes two flip-flops; only the second is read outside.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                dout[i]   <= 1'b0;
            end else begin
                meta_q[i] <= din[i];
                dout[i]   <= meta_q[i];
            end
        end
    end
endmodule // lichg_sync

// ### core/lichg_timebase.sv
// Millisecond tick and indicator blink phase from the single clock.
// Assumes a free-running clk and synchronous active-high rst.
`timescale 1ns/1ns
`include "lichg_cfg.svh"
module lichg_timebase #(
    parameter int TICK_CYC   = `LICHG_TICK_CYC,
    parameter int BLINK_HALF = `LICHG_BLINK_HALF_MS
) (
    input  wire logic  clk,
    input  wire logic  rst,
    lichg_time_if.src  tm
);
    logic [31:0] pre_q;
    logic [15:0] blk_q;
    if (TICK_CYC < 2 || BLINK_HALF < 1 || BLINK_HALF > 65535) begin : g_chk
        $error("lichg_timebase prescale values out of range");
    end
    // Prescaler emits one tick per millisecond.
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q   <= 32'h0;
            tm.tick <= 1'b0;
        end else begin
            tm.tick <= (pre_q == 32'(TICK_CYC - 1));
            pre_q   <= (pre_q == 32'(TICK_CYC - 1)) ? 32'h0 : pre_q + 32'h1;
        end
    end
    // Blink phase toggles every half period, a 50% duty square wave.
    always_ff @(posedge clk) begin
        if (rst) begin
            blk_q    <= 16'h0;
            tm.blink <= 1'b0;
        end else if (tm.tick) begin
            if (blk_q == 16'(BLINK_HALF - 1)) begin
                blk_q    <= 16'h0;
                tm.blink <= ~tm.blink;
            end else begin
                blk_q <= blk_q + 16'h1;
            end
        end
    end
endmodule // lichg_timebase

// ### core/lichg_ctrl.sv
// Charge-mode sequencer for a single-cell lithium-ion charger controller.
// Assumes comparator flags and pins arrive asynchronously; AHB-Lite slave.
`timescale 1ns/1ns
`include "lichg_cfg.svh"
module lichg_ctrl import lichg_pkg::*; #(
    parameter int TICK_CYC = `LICHG_TICK_CYC,
    parameter int SEC_MS   = `LICHG_SECOND_MS,
    parameter int HOUR_MS  = `LICHG_HOUR_MS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        enable,
    input  wire logic        boost,
    input  wire logic        chargeInterruptN,
    input  wire logic        voltageSelect,
    input  wire logic        supplyAboveStart,
    input  wire logic        supplyBelowUvr,
    input  wire logic        vbatAboveCond,
    input  wire logic        vbatOverVolt,
    input  wire logic        currentSenseEoc,
    input  wire logic        currentSenseOver,
    input  wire logic        resistanceFreeOk,
    input  wire logic        vbatAtFloat,
    output logic             passFetDrive,
    output logic             refHighSelect,
    output logic [1:0]       currentRefSelect,
    output logic             statusLedAOut,
    output logic             statusLedAOeN,
    output logic             statusLedBOut,
    output logic             statusLedBOeN
);
    if (HOUR_MS < SEC_MS || HOUR_MS > 4194303 || SEC_MS < 1) begin : g_chk
        $error("lichg_ctrl timer lengths out of range");
    end
    // -------------------------------------------------------------------------
    // Input synchronisation and time base
    // -------------------------------------------------------------------------
    logic [11:0] syn;
    logic enS, boostS, chgOkS, vselS, supOkS, uvS;
    logic vCondS, ovS, eocS, ocS, rfvS, floatS;
    lichg_time_if tmIf ();
    // Every pin and comparator flag goes through two flip-flops.
    lichg_sync #(.W(12)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({vbatAtFloat, resistanceFreeOk, currentSenseOver, currentSenseEoc,
                vbatOverVolt, vbatAboveCond, supplyBelowUvr, supplyAboveStart,
                voltageSelect, chargeInterruptN, boost, enable}),
        .dout (syn)
    );
    lichg_timebase #(.TICK_CYC(TICK_CYC)) u_tb (
        .clk (clk),
        .rst (rst),
        .tm  (tmIf.src)
    );
    // Named views of the synchronised inputs.
    assign {floatS, rfvS, ocS, eocS, ovS, vCondS, uvS, supOkS,
            vselS, chgOkS, boostS, enS} = syn;
    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    lichg_state_e state_q, state_d;
    logic [21:0]  tmr_q;
    logic         swEn_q, enEff, halted, secDone, hourDone, pfd_d, faultIn;
    assign enEff    = enS & swEn_q;
    assign halted   = ~chgOkS & (state_q inside {LC_COND, LC_FAST, LC_EOCWAIT, LC_TOPOFF});
    assign secDone  = tmr_q >= 22'(SEC_MS);
    assign hourDone = tmr_q >= 22'(HOUR_MS);
    assign faultIn  = ovS | ocS;
    // Next mode: undervoltage first, then fault, boost, then mode flow.
    always_comb begin
        state_d = state_q;
        case (state_q)
            LC_RESET:   if (supOkS && secDone) state_d = LC_STANDBY;
            LC_STANDBY: if (enEff) state_d = LC_START;
            LC_START: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (secDone) state_d = ovS ? LC_FAULT
                                          : (vCondS ? LC_FAST : LC_COND);
            end
            LC_COND: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (!halted && vCondS) state_d = LC_FAST;
                else if (!halted && hourDone) state_d = LC_DEFECT;
            end
            LC_FAST: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (!halted && eocS) state_d = LC_EOCWAIT;
            end
            LC_EOCWAIT: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (!halted && secDone) state_d = rfvS ? LC_TOPOFF : LC_DEFECT;
            end
            LC_TOPOFF: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (!halted && hourDone) state_d = LC_MONITOR;
            end
            LC_MONITOR: begin
                if (!enEff) state_d = LC_STANDBY;
                else if (floatS) state_d = LC_FAST;
            end
            LC_BOOST:   if (!boostS || !chgOkS) state_d = LC_STANDBY;
            LC_DEFECT:  if (!enEff) state_d = LC_STANDBY;
            LC_FAULT:   if (!enEff) state_d = LC_STANDBY;
            default:    state_d = LC_RESET;
        endcase
        // Boost overrides enable, except in reset, conditioning, defect and fault or when interrupted.
        if (boostS && chgOkS && (state_q inside {LC_STANDBY, LC_START, LC_FAST,
                LC_EOCWAIT, LC_TOPOFF, LC_MONITOR}))
            state_d = LC_BOOST;
        if (faultIn && !(state_q inside {LC_RESET, LC_STANDBY, LC_FAULT}))
            state_d = LC_FAULT;
        if (uvS) state_d = LC_RESET;
    end
    // Mode register; reset only by rst or the undervoltage flag.
    always_ff @(posedge clk) begin
        if (rst) state_q <= LC_RESET;
        else     state_q <= state_d;
    end
    // Shared millisecond timer, cleared on every mode change, held when halted.
    always_ff @(posedge clk) begin
        if (rst) begin
            tmr_q <= 22'h0;
        end else if (state_d != state_q || (state_q == LC_RESET && !supOkS)) begin
            tmr_q <= 22'h0;
        end else if (tmIf.tick && !halted && !hourDone) begin
            tmr_q <= tmr_q + 22'h1;
        end
    end
    // -------------------------------------------------------------------------
    // Pin drivers
    // -------------------------------------------------------------------------
    // Gate drive is on only in charging modes and while not interrupted.
    assign pfd_d = chgOkS && (state_q inside {LC_COND, LC_FAST, LC_TOPOFF, LC_BOOST});
    always_ff @(posedge clk) begin
        if (rst) passFetDrive <= 1'b0;
        else     passFetDrive <= pfd_d;
    end
    // Voltage and current references follow the select pin and the mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            refHighSelect    <= 1'b0;
            currentRefSelect <= LC_IREF_FAST;
        end else begin
            refHighSelect    <= vselS;
            currentRefSelect <= (state_q == LC_BOOST) ? LC_IREF_BOOST
                              : (state_q == LC_COND) ? LC_IREF_COND : LC_IREF_FAST;
        end
    end
    // Open-drain indicators: enable low sinks the pin.
    always_ff @(posedge clk) begin
        if (rst) begin
            statusLedAOut <= 1'b0;
            statusLedBOut <= 1'b0;
            statusLedAOeN <= 1'b1;
            statusLedBOeN <= 1'b1;
        end else begin
            statusLedAOut <= 1'b0;
            statusLedBOut <= 1'b0;
            case (state_d)
                LC_START, LC_COND, LC_FAST, LC_EOCWAIT: begin
                    statusLedAOeN <= 1'b0;
                    statusLedBOeN <= 1'b1;
                end
                LC_TOPOFF, LC_MONITOR: begin
                    statusLedAOeN <= 1'b1;
                    statusLedBOeN <= 1'b0;
                end
                LC_BOOST: begin
                    statusLedAOeN <= 1'b0;
                    statusLedBOeN <= 1'b0;
                end
                LC_DEFECT: begin
                    statusLedAOeN <= ~tmIf.blink;
                    statusLedBOeN <= 1'b1;
                end
                LC_FAULT: begin
                    statusLedAOeN <= ~tmIf.blink;
                    statusLedBOeN <= ~tmIf.blink;
                end
                default: begin
                    statusLedAOeN <= 1'b1;
                    statusLedBOeN <= 1'b1;
                end
            endcase
        end
    end
    // -------------------------------------------------------------------------
    // AHB-Lite registers and interrupt
    // -------------------------------------------------------------------------
    logic [7:0]             wrAddr_q;
    logic                   wrEn_q, take;
    logic [`LICHG_EV_W-1:0] ist_q, msk_q, evSet, evClr;
    logic [31:0]            rdMux;
    assign take = hsel & hready & htrans[1];
    // Mode entries that software may want to hear about.
    assign evSet = {state_d == LC_RESET && state_q != LC_RESET,
                    state_d == LC_MONITOR && state_q == LC_TOPOFF,
                    state_d == LC_DEFECT && state_q != LC_DEFECT,
                    state_d == LC_FAULT && state_q != LC_FAULT};
    assign evClr = (wrEn_q && wrAddr_q == `LICHG_OFS_ISTAT) ? hwdata[`LICHG_EV_W-1:0]
                                                             : '0;
    // Read mux; unmapped offsets read zero.
    always_comb begin
        case (haddr[7:0])
            `LICHG_OFS_CTRL:   rdMux = {31'h0, swEn_q};
            `LICHG_OFS_STATUS: rdMux = {9'h0, syn, state_q};
            `LICHG_OFS_ISTAT:  rdMux = {28'h0, ist_q};
            `LICHG_OFS_IMASK:  rdMux = {28'h0, msk_q};
            default:           rdMux = 32'h0;
        endcase
    end
    // Address phase capture, registered read data, zero wait, always OKAY.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrEn_q    <= 1'b0;
            wrAddr_q  <= 8'h0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrEn_q    <= take & hwrite;
            wrAddr_q  <= haddr[7:0];
            hrdata    <= (take && !hwrite) ? rdMux : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    // Control, mask and sticky status; a new event wins over its clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            swEn_q <= 1'(`LICHG_CTRL_RST);
            msk_q  <= '0;
            ist_q  <= '0;
            irq    <= 1'b0;
        end else begin
            if (wrEn_q && wrAddr_q == `LICHG_OFS_CTRL) swEn_q <= hwdata[`LICHG_CTRL_EN_BIT];
            if (wrEn_q && wrAddr_q == `LICHG_OFS_IMASK) msk_q <= hwdata[`LICHG_EV_W-1:0];
            ist_q <= (ist_q & ~evClr) | evSet;
            irq   <= |(ist_q & msk_q);
        end
    end
    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_off;
        state_q == LC_RESET |=> !passFetDrive;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("gate on in reset");
    property p_uvr;
        uvS |=> state_q == LC_RESET;
    endproperty
    a_uvr: assert property (p_uvr) else $error("undervoltage missed");
    property p_leave_rst;
        $past(state_q) == LC_RESET && state_q == LC_STANDBY |-> $past(secDone) && $past(supOkS);
    endproperty
    a_leave_rst: assert property (p_leave_rst) else $error("early reset exit");
    property p_intr;
        !chgOkS |=> !passFetDrive;
    endproperty
    a_intr: assert property (p_intr) else $error("gate on while interrupted");
    property p_no_boost;
        !chgOkS |=> state_q != LC_BOOST;
    endproperty
    a_no_boost: assert property (p_no_boost) else $error("boost while interrupted");
    property p_vsel;
        ##1 refHighSelect == $past(vselS);
    endproperty
    a_vsel: assert property (p_vsel) else $error("reference select lags");
    property p_fault;
        state_q == LC_FAULT && enEff && !uvS |=> state_q == LC_FAULT ##1 !passFetDrive;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not held");
    property p_defect_led;
        state_q == LC_DEFECT ##1 state_q == LC_DEFECT |-> statusLedBOeN && !passFetDrive;
    endproperty
    a_defect_led: assert property (p_defect_led) else $error("defect indicators");
    property p_standby_led;
        state_q == LC_STANDBY ##1 state_q == LC_STANDBY |-> statusLedAOeN && statusLedBOeN;
    endproperty
    a_standby_led: assert property (p_standby_led) else $error("standby leds");
    c_monitor: cover property (state_q == LC_TOPOFF ##1 state_q == LC_MONITOR);
    c_defect:  cover property (state_q == LC_EOCWAIT ##1 state_q == LC_DEFECT);
    c_fault:   cover property (state_q == LC_FAST ##1 state_q == LC_FAULT);
endmodule // lichg_ctrl

// ### verification/lichg_pack_model.sv
// Battery pack model: cell charge rises while the gate is on.
// Assumes the controller's clock; flags are plain comparator levels.
`timescale 1ns/1ns
module lichg_pack_model (
    input  wire logic clk,
    input  wire logic passFetDrive,
    input  wire logic deadCell,
    input  wire logic openPack,
    output logic      vbatAboveCond,
    output logic      currentSenseEoc,
    output logic      resistanceFreeOk,
    output logic      vbatAtFloat
);
    logic [7:0] level_q = 8'h00;
    logic [5:0] droop_q = 6'h00;
    // A dead cell never takes charge; an idle cell droops slowly.
    always_ff @(posedge clk) begin
        droop_q <= droop_q + 6'h01;
        if (deadCell) begin
            level_q <= 8'h00;
        end else if (passFetDrive && level_q < 8'hc0) begin
            level_q <= level_q + 8'h01;
        end else if (!passFetDrive && droop_q == 6'h3f && level_q > 8'h00) begin
            level_q <= level_q - 8'h01;
        end
    end
    // Comparator levels seen by the controller.
    assign vbatAboveCond    = level_q >= 8'h10;
    assign currentSenseEoc  = level_q >= 8'hc0;
    assign resistanceFreeOk = !openPack;
    assign vbatAtFloat      = level_q <= 8'hbd;
endmodule // lichg_pack_model

// ### verification/lichg_ctrl_tb.sv
// Self-checking bench for the charge-mode controller.
// Assumes short time parameters: one second is 12 cycles, one hour 40.
`timescale 1ns/1ns
module lichg_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp, irq;
    logic [1:0]  htrans = 2'h0, currentRefSelect;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic        enable = 1'b0, boost = 1'b0, chargeInterruptN = 1'b1, voltageSelect = 1'b0;
    logic        supplyAboveStart = 1'b0, supplyBelowUvr = 1'b0, vbatOverVolt = 1'b0;
    logic        currentSenseOver = 1'b0, deadCell = 1'b0, openPack = 1'b0, a;
    logic        vbatAboveCond, currentSenseEoc, resistanceFreeOk, vbatAtFloat;
    logic        passFetDrive, refHighSelect, statusLedAOut, statusLedAOeN;
    logic        statusLedBOut, statusLedBOeN;
    int          fails = 0, testsRun = 0, cyc = 0, n, w;
    // Pin levels with the board pull-ups on the open-drain indicators.
    wire ledA = statusLedAOeN ? 1'b1 : statusLedAOut;
    wire ledB = statusLedBOeN ? 1'b1 : statusLedBOut;
    always #2 clk = ~clk;
    lichg_ctrl #(.TICK_CYC(4), .SEC_MS(3), .HOUR_MS(10)) lichg_ctrl_inst (
        .clk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .enable, .boost,
        .chargeInterruptN, .voltageSelect, .supplyAboveStart, .supplyBelowUvr,
        .vbatAboveCond, .vbatOverVolt, .currentSenseEoc, .currentSenseOver,
        .resistanceFreeOk, .vbatAtFloat, .passFetDrive, .refHighSelect,
        .currentRefSelect, .statusLedAOut, .statusLedAOeN, .statusLedBOut, .statusLedBOeN);
    lichg_pack_model lichg_pack_model_inst (
        .clk, .passFetDrive, .deadCell, .openPack, .vbatAboveCond,
        .currentSenseEoc, .resistanceFreeOk, .vbatAtFloat);
    // -------------------------------------------------------------------------
    // Bus and compare tasks
    // -------------------------------------------------------------------------
    // One AHB-Lite single word transfer; waits on hready in both phases.
    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
        int k;
        k = 0;
        @(posedge clk);
        haddr <= {24'h0, ad};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++k < 100);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++k < 200);
        rd = hrdata;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Polls the mode field until the given one-hot bit shows.
    task automatic waitMode(input int b, input int lim);
        int k;
        k = 0;
        do begin ahb(1'b0, 8'h04, 32'h0, d); k++; end while (d[b] !== 1'b1 && k < lim);
        chk(d[b], 1'b1);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            tally_and_finish;
        end
    end
    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    // Power-up, references, a full charge cycle, faults, defects, brown-out.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, 8'h00, 32'h0, d); chk(d, 32'h1);
        ahb(1'b0, 8'h08, 32'h0, d); chk(d, 32'h0);
        ahb(1'b0, 8'h0c, 32'h0, d); chk(d, 32'h0);
        ahb(1'b0, 8'h10, 32'h0, d); chk(d, 32'h0);
        chk({passFetDrive, ledA, ledB, hresp, hreadyout}, 5'hd);
        supplyAboveStart <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(1'b0, 8'h04, 32'h0, d); chk(d[10:0], 11'h001);
        waitMode(1, 20);
        supplyAboveStart <= 1'b0;
        repeat (20) @(posedge clk);
        ahb(1'b0, 8'h04, 32'h0, d); chk(d[10:0], 11'h002);
        for (n = 1; n >= 0; n--) begin
            voltageSelect <= n[0];
            repeat (5) @(posedge clk);
            chk(refHighSelect, n[0]);
        end
        ahb(1'b1, 8'h0c, 32'h4, d);
        enable <= 1'b1;
        waitMode(2, 10);
        chk({passFetDrive, ledA, ledB}, 3'h1);
        waitMode(3, 20);
        chk({passFetDrive, currentRefSelect}, 3'h5);
        waitMode(4, 40);
        chk({currentRefSelect, ledA, ledB}, 4'h1);
        chargeInterruptN <= 1'b0;
        boost <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(passFetDrive, 1'b0);
        ahb(1'b0, 8'h04, 32'h0, d); chk({d[10:0], currentRefSelect}, 13'h40);
        boost <= 1'b0;
        chargeInterruptN <= 1'b1;
        repeat (5) @(posedge clk);
        chk(passFetDrive, 1'b1);
        boost <= 1'b1;
        waitMode(8, 10);
        chk({currentRefSelect, ledA, ledB}, 4'h8);
        boost <= 1'b0;
        waitMode(5, 100);
        chk(passFetDrive, 1'b0);
        waitMode(6, 20);
        chk({ledA, ledB}, 2'h2);
        waitMode(7, 30);
        chk({passFetDrive, irq}, 2'h1);
        ahb(1'b1, 8'h08, 32'h4, d);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        waitMode(4, 150);
        for (n = 0; n < 2; n++) begin
            enable <= 1'b1;
            waitMode(4, 40);
            if (n == 0) vbatOverVolt <= 1'b1;
            else currentSenseOver <= 1'b1;
            waitMode(10, 10);
            chk(passFetDrive, 1'b0);
            a = ledA;
            for (w = 0; ledA === a && w < 6000; w++) @(posedge clk);
            chk({ledB, w < 5100}, {ledA, 1'b1});
            vbatOverVolt <= 1'b0;
            currentSenseOver <= 1'b0;
            repeat (30) @(posedge clk);
            ahb(1'b0, 8'h04, 32'h0, d); chk(d[10], 1'b1);
            enable <= 1'b0;
            waitMode(1, 10);
        end
        ahb(1'b0, 8'h08, 32'h0, d); chk({d[0], irq}, 2'h2);
        openPack <= 1'b1;
        enable <= 1'b1;
        waitMode(9, 150);
        chk({passFetDrive, ledB}, 2'h1);
        enable <= 1'b0;
        deadCell <= 1'b1;
        waitMode(1, 10);
        enable <= 1'b1;
        waitMode(3, 20);
        waitMode(9, 40);
        chk({passFetDrive, ledB}, 2'h1);
        supplyBelowUvr <= 1'b1;
        waitMode(0, 10);
        chk(passFetDrive, 1'b0);
        ahb(1'b0, 8'h08, 32'h0, d); chk(d[3], 1'b1);
        tally_and_finish;
    end
endmodule // lichg_ctrl_tb
